// *** hw/acdr_pkg.sv ***
// Purpose: Constants and carriers for the AGC config and test DAC register bank
// Assumes: Byte registers on 32-bit Avalon-MM words, index times four
// Notes:   Offsets kept as printed indices
package acdr_pkg;
    localparam int          ADDR_W           = 8;
    localparam logic [7:0]  IDX_TEST_SELECT  = 8'h1C;
    localparam logic [7:0]  IDX_GAIN_CLIP    = 8'h1E;
    localparam logic [7:0]  IDX_SAT_THRESH   = 8'h20;
    localparam logic [7:0]  IDX_RF_PAD       = 8'h22;
    localparam logic [7:0]  IDX_HIGH_SAT     = 8'h24;
    localparam logic [7:0]  IDX_LOCKIN_CW    = 8'h26;
    localparam logic [7:0]  IDX_LOCK_POS     = 8'h28;
    localparam logic [7:0]  IDX_BACKOFF      = 8'h2A;
    localparam logic [7:0]  IDX_TABLE_ADDR   = 8'h2C;
    localparam logic [7:0]  IDX_TABLE_DATA   = 8'h2E;
    localparam logic [7:0]  IDX_LOW_MID_ATT  = 8'h38;
    localparam logic [7:0]  IDX_TEST_MODE    = 8'h40;
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    localparam logic [7:0]  RST_RF_PAD       = 8'h1E;
    localparam int          OBS_LSB          = 4;
    localparam int          TB_EN_BIT        = 3;
    localparam int          RFAD_EN_BIT      = 2;
    localparam int          TBL_RD_BIT       = 5;
    localparam int          LOWRATE_BIT      = 7;
    localparam int          TB_INPUT_BIT     = 4;
    localparam logic [3:0]  CW_FORCE_ON      = 4'h0;
    localparam logic [3:0]  CW_FORCE_OFF     = 4'hF;
    localparam logic [5:0]  SYNC_NEG         = 6'h20;
    localparam int          CMF_TAPS         = 16;
    localparam logic [3:0]  CMF_LAST         = 4'hF;

    typedef enum logic [7:0] {
        ACDR_OBS_TXF   = 8'h01,
        ACDR_OBS_DOWN  = 8'h02,
        ACDR_OBS_EL    = 8'h04,
        ACDR_OBS_IQAD  = 8'h08,
        ACDR_OBS_BIG   = 8'h10,
        ACDR_OBS_CMF   = 8'h20,
        ACDR_OBS_TBUS  = 8'h40,
        ACDR_OBS_BARK  = 8'h80
    } acdr_obs_e;

    typedef struct packed {
        logic [5:0] i;
        logic [5:0] q;
    } acdr_iq_s;

    typedef struct packed {
        logic [6:0] gain_clip;
        logic [3:0] mid_sat_count;
        logic [3:0] low_sat_count;
        logic [5:0] rf_pad_db;
        logic [4:0] high_sat_step;
        logic [3:0] high_sat_count;
        logic [4:0] mid_sat_step;
        logic [3:0] low_sat_step;
        logic [4:0] lockin_level;
        logic [4:0] lock_window_pos;
        logic [2:0] max_lock_count;
    } acdr_agc_s;
endpackage

// *** hw/acdr_regs.sv ***
// What this block does
// R1 - Select 000 TX filter, 001 down converter, 011 I/Q A/D onto DAC.
// R2 - Select 010 puts chip timing accumulator top six bits on Q, zeros on I.
// R3 - Select 100 puts winning transform I and Q top six bits on DAC.
// R4 - Select 101 cycles sixteen filter weights with negative sync pulse between each.
// R5 - Select 110 feeds six test bus pins to both DACs when pins are inputs.
// R6 - Select 111 shows Barker or low rate samples per test mode bit.
// R7 - Test bus enable routes bus into RX and TX DAC if RF A/D route off.
// R8 - RF A/D route enable sends RF A/D into RX DAC, overriding test bus.
// R9 - Attenuator accumulator clamped between zero and programmed seven-bit clip.
// R10 - Unused bits store and read back, with no effect inside.
// R11 - Mid and low saturation thresholds held; steps apply when count exceeds them.
// R12 - Six-bit RF pad value feeds the signal strength calculation, reset 30 dB.
// R13 - High saturation step is twice programmed value when count exceeds threshold.
// R14 - CW scale 00h forces detector on, 0Fh forces it off.
// R15 - Five-bit lock-in level supplied as inner lock window.
// R16 - Diversity search allowed only when updates to lock at most max count.
// R17 - Five-bit positive outer lock window supplied to lock decision.
// R18 - Table read bit set returns table entry at address, else stored data.
// R19 - Table data register carries seven-bit unsigned data in low bits.
// R20 - Low rate select bit chooses Barker at 0, low rate samples at 1.
// R21 - Test bus input bit releases drivers and makes pins inputs.
// R22 - Writes act next clock; fields read back unchanged except table redirect.
// Purpose: Register bank steering test DAC routing and AGC settings
// Assumes: Avalon-MM slave, one-cycle waitrequest on every access
// Notes:   Datapath inputs are sampled as synchronous to core_clk
`timescale 1ns/1ns
module acdr_regs (
    input  wire logic                              core_clk,
    input  wire logic                              rst_b,
    input  wire logic [acdr_pkg::ADDR_W+1:0]       avs_address,
    input  wire logic                              avs_read,
    input  wire logic                              avs_write,
    input  wire logic [31:0]                       avs_writedata,
    input  wire logic [3:0]                        avs_byteenable,
    output logic      [31:0]                       avs_readdata,
    output logic                                   avs_waitrequest,
    input  wire acdr_pkg::acdr_iq_s                tx_filter_iq,
    input  wire acdr_pkg::acdr_iq_s                down_conv_iq,
    input  wire acdr_pkg::acdr_iq_s                iq_adc_iq,
    input  wire logic [5:0]                        chip_timing_accumulator,
    input  wire logic [5:0]                        transform_winner_inphase,
    input  wire logic [5:0]                        transform_winner_quadrature,
    input  wire logic [95:0]                       matched_filter_weights,
    input  wire acdr_pkg::acdr_iq_s                barker_iq,
    input  wire acdr_pkg::acdr_iq_s                low_rate_iq,
    input  wire logic [5:0]                        rf_adc_sample,
    input  wire logic [5:0]                        tx_dac_normal,
    input  wire logic [5:0]                        rx_dac_normal,
    input  wire logic [5:0]                        test_bus_in,
    input  wire logic [5:0]                        test_bus_drive,
    input  wire logic [7:0]                        atten_acc_raw,
    input  wire logic [3:0]                        sat_count,
    input  wire logic [2:0]                        lock_update_count,
    input  wire logic [3:0]                        cw_detect_raw,
    output acdr_pkg::acdr_iq_s                     iq_dac,
    output logic      [5:0]                        tx_dac,
    output logic      [5:0]                        rx_dac,
    output logic      [5:0]                        test_bus_out,
    output logic      [5:0]                        test_bus_oe,
    output logic      [6:0]                        atten_acc,
    output logic      [4:0]                        sat_step,
    output logic                                   diversity_allow,
    output logic                                   cw_detect,
    output acdr_pkg::acdr_agc_s                    agc_cfg,
    output logic      [1:0]                        reference_trim
);
    localparam int NREG = 12;

    logic [1:0]  rst_sync;
    logic        rst_n;
    logic [7:0]  regs [NREG];
    logic [6:0]  agc_table [32];
    logic [3:0]  cmf_idx;
    logic        cmf_sync;
    logic        ack;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    function automatic int reg_slot(input logic [7:0] idx);
        int s;
        s = -1;
        unique case (idx)
            acdr_pkg::IDX_TEST_SELECT: s = 0;
            acdr_pkg::IDX_GAIN_CLIP:   s = 1;
            acdr_pkg::IDX_SAT_THRESH:  s = 2;
            acdr_pkg::IDX_RF_PAD:      s = 3;
            acdr_pkg::IDX_HIGH_SAT:    s = 4;
            acdr_pkg::IDX_LOCKIN_CW:   s = 5;
            acdr_pkg::IDX_LOCK_POS:    s = 6;
            acdr_pkg::IDX_BACKOFF:     s = 7;
            acdr_pkg::IDX_TABLE_ADDR:  s = 8;
            acdr_pkg::IDX_TABLE_DATA:  s = 9;
            acdr_pkg::IDX_LOW_MID_ATT: s = 10;
            acdr_pkg::IDX_TEST_MODE:   s = 11;
            default:                   s = -1;
        endcase
        return s;
    endfunction

    // Word address; byte address bits 1:0 dropped
    wire [7:0] idx      = avs_address[acdr_pkg::ADDR_W+1:2];
    wire       req      = (avs_read || avs_write) && !ack;
    // Write lands only at the edge where waitrequest is seen low
    wire       wr_go    = avs_write && ack && avs_byteenable[0];
    wire integer slot   = reg_slot(idx);
    wire [7:0] sel      = regs[0];
    wire [7:0] tbl_addr = regs[8];
    wire [7:0] tmode    = regs[11];
    wire       tbl_rd   = tbl_addr[acdr_pkg::TBL_RD_BIT];
    wire       tb_input = tmode[acdr_pkg::TB_INPUT_BIT];

    // Table read-back redirect on the data register
    wire [7:0] rd_byte  = (slot < 0) ? 8'h00 :
                          (slot == 9 && tbl_rd) ? {1'b0, agc_table[tbl_addr[4:0]]} :
                          regs[slot];

    // Table entry takes the write only while redirect is on
    always_ff @(posedge core_clk) begin
        if (wr_go && slot == 9 && tbl_rd) begin
            agc_table[tbl_addr[4:0]] <= avs_writedata[6:0]; // R19
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < NREG; k++) begin
                regs[k] <= (k == 3) ? acdr_pkg::RST_RF_PAD : acdr_pkg::RST_BYTE;
            end
        end else if (wr_go && slot >= 0 && !(slot == 9 && tbl_rd)) begin
            regs[slot] <= avs_writedata[7:0]; // R10 R22
        end
    end

    // Waitrequest idles high; one wait cycle lets read data come from a flop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !req;
            if (avs_read && req) begin
                avs_readdata <= {24'h00_0000, rd_byte}; // R18
            end
        end
    end
    assign ack = !avs_waitrequest;

    // Observation multiplexer
    acdr_pkg::acdr_obs_e obs;
    wire [2:0] obs_code = sel[acdr_pkg::OBS_LSB+2:acdr_pkg::OBS_LSB];
    assign obs = acdr_pkg::acdr_obs_e'(8'h01 << obs_code);

    wire [5:0] cmf_word = matched_filter_weights[cmf_idx*6 +: 6];
    acdr_pkg::acdr_iq_s next_iq;
    always_comb begin
        next_iq = '0;
        unique case (obs)
            acdr_pkg::ACDR_OBS_TXF:  next_iq = tx_filter_iq; // R1
            acdr_pkg::ACDR_OBS_DOWN: next_iq = down_conv_iq; // R1
            acdr_pkg::ACDR_OBS_EL:   next_iq = '{i: 6'h00, q: chip_timing_accumulator}; // R2
            acdr_pkg::ACDR_OBS_IQAD: next_iq = iq_adc_iq; // R1
            acdr_pkg::ACDR_OBS_BIG:  next_iq = '{i: transform_winner_inphase,
                                                q: transform_winner_quadrature}; // R3
            acdr_pkg::ACDR_OBS_CMF:  next_iq = cmf_sync ? {acdr_pkg::SYNC_NEG, acdr_pkg::SYNC_NEG}
                                                        : {cmf_word, cmf_word}; // R4
            acdr_pkg::ACDR_OBS_TBUS: next_iq = tb_input ? {test_bus_in, test_bus_in}
                                                        : '0; // R5
            acdr_pkg::ACDR_OBS_BARK: next_iq = tmode[acdr_pkg::LOWRATE_BIT] ? low_rate_iq
                                                                            : barker_iq; // R6 R20
        endcase
    end

    // Weight walk alternates sync pulse and weight
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmf_idx  <= 4'h0;
            cmf_sync <= 1'b1;
        end else if (obs == acdr_pkg::ACDR_OBS_CMF) begin
            cmf_sync <= !cmf_sync; // R4
            if (!cmf_sync) begin
                cmf_idx <= cmf_idx + 4'h1;
            end
        end else begin
            cmf_idx  <= 4'h0;
            cmf_sync <= 1'b1;
        end
    end

    // RF A/D route wins over test bus route
    wire rfad_en = sel[acdr_pkg::RFAD_EN_BIT];
    wire tb_en   = sel[acdr_pkg::TB_EN_BIT] && !rfad_en; // R7
    wire [5:0] next_rx = rfad_en ? rf_adc_sample : tb_en ? test_bus_in : rx_dac_normal; // R8
    wire [5:0] next_tx = tb_en ? test_bus_in : tx_dac_normal; // R7

    // AGC derived values
    wire [6:0] clip      = regs[1][6:0];
    wire [6:0] next_att  = (atten_acc_raw[7]) ? 7'h00 :
                           (atten_acc_raw[6:0] > clip) ? clip : atten_acc_raw[6:0]; // R9
    wire [3:0] hi_step   = regs[4][7:4];
    wire [3:0] mid_step  = regs[10][7:4];
    wire [4:0] next_step = (sat_count > regs[4][3:0]) ? {hi_step, 1'b0} : // R13
                           (sat_count > regs[2][7:4]) ? {mid_step, 1'b0} : // R11
                           (sat_count > regs[2][3:0]) ? {1'b0, regs[10][3:0]} : 5'h00; // R11
    wire [3:0] cw_scale  = regs[5][3:0];
    wire       next_cw   = (cw_scale == acdr_pkg::CW_FORCE_ON)  ? 1'b1 :
                           (cw_scale == acdr_pkg::CW_FORCE_OFF) ? 1'b0 :
                           (cw_detect_raw >= cw_scale); // R14
    wire [2:0] max_lock  = regs[6][7:5];

    acdr_pkg::acdr_agc_s next_cfg;
    assign next_cfg = '{gain_clip:       clip,
                        mid_sat_count:   regs[2][7:4],
                        low_sat_count:   regs[2][3:0],
                        rf_pad_db:       regs[3][5:0], // R12
                        high_sat_step:   {hi_step, 1'b0}, // R13
                        high_sat_count:  regs[4][3:0],
                        mid_sat_step:    {mid_step, 1'b0},
                        low_sat_step:    regs[10][3:0],
                        lockin_level:    regs[5][4:0], // R15
                        lock_window_pos: regs[6][4:0], // R17
                        max_lock_count:  max_lock};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            iq_dac          <= '0;
            tx_dac          <= 6'h00;
            rx_dac          <= 6'h00;
            test_bus_out    <= 6'h00;
            test_bus_oe     <= 6'h00;
            atten_acc       <= 7'h00;
            sat_step        <= 5'h00;
            diversity_allow <= 1'b0;
            cw_detect       <= 1'b0;
            agc_cfg         <= '0;
            reference_trim  <= 2'b00;
        end else begin
            iq_dac          <= next_iq;
            tx_dac          <= next_tx;
            rx_dac          <= next_rx;
            test_bus_out    <= test_bus_drive;
            test_bus_oe     <= {6{!tb_input}}; // R21
            atten_acc       <= next_att;
            sat_step        <= next_step;
            diversity_allow <= (lock_update_count <= max_lock); // R16
            cw_detect       <= next_cw;
            agc_cfg         <= next_cfg;
            reference_trim  <= sel[1:0];
        end
    end

    sequence s_wr_ack;
        avs_write && !avs_waitrequest;
    endsequence

    // Sampled rst_n in antecedents skips the edge where outputs still leave reset
    a_clip_bound: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
        atten_acc <= $past(clip)) else $error("Attenuator above clip");
    a_rfad_wins: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
        rfad_en |=> rx_dac == $past(rf_adc_sample)) else $error("RF A/D route lost");
    a_tb_tx_route: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
        tb_en |=> tx_dac == $past(test_bus_in)) else $error("Test bus not on TX DAC");
    a_el_zero_i: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
        obs == acdr_pkg::ACDR_OBS_EL |=> iq_dac.i == 6'h00
        && iq_dac.q == $past(chip_timing_accumulator)) else $error("E/L mux wrong");
    a_cw_forced: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
        rst_n && cw_scale == acdr_pkg::CW_FORCE_ON |=> cw_detect)
        else $error("CW not forced on");
    a_cw_off: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
        cw_scale == acdr_pkg::CW_FORCE_OFF |=> !cw_detect) else $error("CW not off");
    a_hi_step_dbl: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
        sat_count > regs[4][3:0] |=> sat_step == {$past(hi_step), 1'b0})
        else $error("High step wrong");
    a_div_allow: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
        lock_update_count > max_lock |=> !diversity_allow) else $error("Diversity leak");
    a_write_next: assert property (@(posedge core_clk) disable iff (!rst_n) // R22
        s_wr_ack ##0 (slot == 3 && avs_byteenable[0]) |=> regs[3] == $past(avs_writedata[7:0]))
        else $error("Write not stored");
    a_cmf_sync: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
        obs == acdr_pkg::ACDR_OBS_CMF && cmf_sync |=> iq_dac.i == acdr_pkg::SYNC_NEG)
        else $error("Sync pulse missing");
    a_txf_route: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
        rst_n && obs == acdr_pkg::ACDR_OBS_TXF |=> iq_dac == $past(tx_filter_iq))
        else $error("TX filter not on DAC");
    a_big_pick: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
        obs == acdr_pkg::ACDR_OBS_BIG |=> iq_dac.i == $past(transform_winner_inphase)
        && iq_dac.q == $past(transform_winner_quadrature)) else $error("Picker not on DAC");
    a_tbus_feed: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
        obs == acdr_pkg::ACDR_OBS_TBUS && tb_input |=> iq_dac.i == $past(test_bus_in)
        && iq_dac.q == $past(test_bus_in)) else $error("Test bus not on DAC");
    a_low_rate: assert property (@(posedge core_clk) disable iff (!rst_n) // R6 R20
        obs == acdr_pkg::ACDR_OBS_BARK && tmode[acdr_pkg::LOWRATE_BIT]
        |=> iq_dac == $past(low_rate_iq)) else $error("Low rate samples missing");
    a_oe_release: assert property (@(posedge core_clk) disable iff (!rst_n) // R21
        tb_input |=> test_bus_oe == 6'h00) else $error("Test bus still driven");
    a_table_width: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
        avs_read && req && slot == 9 && tbl_rd |=> !avs_readdata[7])
        else $error("Table data too wide");
    a_low_step: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
        sat_count > regs[2][3:0] && sat_count <= regs[2][7:4] && sat_count <= regs[4][3:0]
        |=> sat_step == {1'b0, $past(regs[10][3:0])}) else $error("Low step wrong");
endmodule

// *** test/acdr_regs_tb.sv ***
// Purpose: Self-checking bench for the AGC config and test DAC register bank
// Assumes: Outputs settle one edge after inputs or after a register write lands
// Notes:   Waitrequest and readdata are taken at the rising edge that ends the wait
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module acdr_regs_tb;
    logic                core_clk, rst_b, avs_read, avs_write, avs_waitrequest;
    logic [9:0]          avs_address;
    logic [31:0]         avs_writedata, avs_readdata;
    logic [3:0]          avs_byteenable, sat_count, cw_detect_raw;
    acdr_pkg::acdr_iq_s  tx_filter_iq, down_conv_iq, iq_adc_iq, barker_iq, low_rate_iq, iq_dac;
    logic [5:0]          chip_timing_accumulator, transform_winner_inphase;
    logic [5:0]          transform_winner_quadrature, rf_adc_sample, tx_dac_normal;
    logic [5:0]          rx_dac_normal, test_bus_in, test_bus_drive;
    logic [5:0]          tx_dac, rx_dac, test_bus_out, test_bus_oe;
    logic [95:0]         matched_filter_weights;
    logic [7:0]          atten_acc_raw, rd_val;
    logic [2:0]          lock_update_count;
    logic [6:0]          atten_acc;
    logic [4:0]          sat_step;
    logic                diversity_allow, cw_detect;
    acdr_pkg::acdr_agc_s agc_cfg;
    logic [1:0]          reference_trim;
    int                  err_count, checks_done;
    logic [7:0]          regs [9] = '{8'h1C, 8'h1E, 8'h20, 8'h22, 8'h24, 8'h26, 8'h28, 8'h2A, 8'h2C};

    acdr_regs DUT (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_filter_iq(tx_filter_iq),
        .down_conv_iq(down_conv_iq), .iq_adc_iq(iq_adc_iq),
        .chip_timing_accumulator(chip_timing_accumulator),
        .transform_winner_inphase(transform_winner_inphase),
        .transform_winner_quadrature(transform_winner_quadrature),
        .matched_filter_weights(matched_filter_weights), .barker_iq(barker_iq),
        .low_rate_iq(low_rate_iq), .rf_adc_sample(rf_adc_sample), .tx_dac_normal(tx_dac_normal),
        .rx_dac_normal(rx_dac_normal), .test_bus_in(test_bus_in), .test_bus_drive(test_bus_drive),
        .atten_acc_raw(atten_acc_raw), .sat_count(sat_count),
        .lock_update_count(lock_update_count), .cw_detect_raw(cw_detect_raw), .iq_dac(iq_dac),
        .tx_dac(tx_dac), .rx_dac(rx_dac), .test_bus_out(test_bus_out), .test_bus_oe(test_bus_oe),
        .atten_acc(atten_acc), .sat_step(sat_step), .diversity_allow(diversity_allow),
        .cw_detect(cw_detect), .agc_cfg(agc_cfg), .reference_trim(reference_trim));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic wrap_up;
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One Avalon access; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd_val = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            wrap_up();
        end
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] ex);
        bus(1'b0, idx, 8'h00);
        `CHK("readdata", ex, rd_val)
    endtask

    task automatic settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset;
        foreach (regs[k]) rchk(regs[k], regs[k] == 8'h22 ? acdr_pkg::RST_RF_PAD : 8'h00);
        `CHK("rf_pad_db", 6'h1E, agc_cfg.rf_pad_db)
    endtask

    task automatic t_readback;
        foreach (regs[k]) begin
            bus(1'b1, regs[k], 8'hFF - 8'(k));
            rchk(regs[k], 8'hFF - 8'(k));
            bus(1'b1, regs[k], 8'h00);
        end
        bus(1'b1, 8'h30, 8'hFF);
        rchk(8'h30, 8'h00);
    endtask

    task automatic t_obs;
        acdr_pkg::acdr_iq_s ex;
        int                 n;
        int                 o;
        bus(1'b1, 8'h40, 8'h10);
        for (int s = 0; s < 9; s++) begin
            // Pass 8 repeats select 111 with the low rate bit set
            o = (s == 8) ? 7 : s;
            if (s == 8)
                bus(1'b1, 8'h40, 8'h90);
            bus(1'b1, 8'h1C, {1'b0, 3'(o), 4'h0});
            settle();
            case (o)
                3'd0: ex = tx_filter_iq;
                3'd1: ex = down_conv_iq;
                3'd2: ex = {6'h00, chip_timing_accumulator};
                3'd3: ex = iq_adc_iq;
                3'd4: ex = {transform_winner_inphase, transform_winner_quadrature};
                3'd6: ex = {test_bus_in, test_bus_in};
                default: ex = (s == 8) ? low_rate_iq : barker_iq;
            endcase
            if (s == 5) begin
                n = 0;
                repeat (32) begin
                    @(posedge core_clk);
                    #1;
                    if (iq_dac.i === acdr_pkg::SYNC_NEG)
                        n++;
                end
                `CHK("cmf_sync_count", 16, n)
            end else
                `CHK("iq_dac", ex, iq_dac)
        end
        `CHK("test_bus_oe", 6'h00, test_bus_oe)
        bus(1'b1, 8'h40, 8'h00);
        settle();
        `CHK("test_bus_oe", 6'h3F, test_bus_oe)
        `CHK("test_bus_out", test_bus_drive, test_bus_out)
    endtask

    task automatic t_route;
        logic [7:0] cfg [4] = '{8'h01, 8'h0A, 8'h07, 8'h0C};
        bus(1'b1, 8'h40, 8'h10);
        foreach (cfg[k]) begin
            bus(1'b1, 8'h1C, cfg[k]);
            settle();
            `CHK("tx_dac", k == 1 ? test_bus_in : tx_dac_normal, tx_dac)
            `CHK("rx_dac", k == 1 ? test_bus_in : k > 1 ? rf_adc_sample : rx_dac_normal, rx_dac)
            `CHK("reference_trim", cfg[k][1:0], reference_trim)
        end
    endtask

    task automatic t_agc;
        logic [7:0] raw [3] = '{8'h11, 8'h85, 8'h05};
        logic [6:0] exa [3] = '{7'h10, 7'h00, 7'h05};
        logic [4:0] exs [4] = '{5'h0A, 5'h04, 5'h01, 5'h00};
        bus(1'b1, 8'h1E, 8'h10);
        bus(1'b1, 8'h20, 8'h21);
        bus(1'b1, 8'h38, 8'h21);
        bus(1'b1, 8'h24, 8'h53);
        foreach (raw[k]) begin
            @(posedge core_clk);
            atten_acc_raw <= raw[k];
            settle();
            `CHK("atten_acc", exa[k], atten_acc)
        end
        `CHK("gain_clip", 7'h10, agc_cfg.gain_clip)
        `CHK("high_sat_step", 5'h0A, agc_cfg.high_sat_step)
        foreach (exs[k]) begin
            @(posedge core_clk);
            sat_count <= 4'(4 - k);
            settle();
            `CHK("sat_step", exs[k], sat_step)
        end
    endtask

    task automatic t_lock;
        bus(1'b1, 8'h28, 8'h6B);
        bus(1'b1, 8'h26, 8'h13);
        settle();
        `CHK("lock_window_pos", 5'h0B, agc_cfg.lock_window_pos)
        `CHK("lockin_level", 5'h13, agc_cfg.lockin_level)
        for (int c = 3; c < 5; c++) begin
            @(posedge core_clk);
            lock_update_count <= 3'(c);
            settle();
            `CHK("diversity_allow", c == 3 ? 1'b1 : 1'b0, diversity_allow)
        end
        // Raw level at full scale would trip the normal compare at 0Fh
        @(posedge core_clk);
        cw_detect_raw <= 4'hF;
        bus(1'b1, 8'h26, 8'h00);
        settle();
        `CHK("cw_detect", 1'b1, cw_detect)
        bus(1'b1, 8'h26, 8'h0F);
        settle();
        `CHK("cw_detect", 1'b0, cw_detect)
    endtask

    task automatic t_table;
        bus(1'b1, 8'h2C, 8'h25);
        bus(1'b1, 8'h2E, 8'h55);
        rchk(8'h2E, 8'h55);
        bus(1'b1, 8'h2C, 8'h05);
        rchk(8'h2E, 8'h00);
        bus(1'b1, 8'h2E, 8'h81);
        rchk(8'h2E, 8'h81);
        bus(1'b1, 8'h2C, 8'h25);
        rchk(8'h2E, 8'h55);
    endtask

    initial begin
        rst_b = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        tx_filter_iq = {6'h01, 6'h02};
        down_conv_iq = {6'h03, 6'h04};
        iq_adc_iq = {6'h05, 6'h06};
        barker_iq = {6'h0A, 6'h0B};
        low_rate_iq = {6'h0C, 6'h0D};
        chip_timing_accumulator = 6'h07;
        transform_winner_inphase = 6'h08;
        transform_winner_quadrature = 6'h09;
        {test_bus_in, test_bus_drive} = {6'h0E, 6'h0E};
        {rf_adc_sample, tx_dac_normal, rx_dac_normal} = {6'h11, 6'h12, 6'h13};
        {atten_acc_raw, sat_count, lock_update_count, cw_detect_raw} = '0;
        for (int k = 0; k < 16; k++)
            matched_filter_weights[6 * k +: 6] = 6'(k + 1);
        {err_count, checks_done} = '0;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_readback();
        t_obs();
        t_route();
        t_agc();
        t_lock();
        t_table();
        wrap_up();
    end
endmodule
